// file: verilog/irctu_cfg.svh
// Register offsets, trap condition codes and field constants of the unit.
// Assumes inclusion by bare name from the datapath module and the testbench.
`ifndef IRCTU_CFG_SVH
`define IRCTU_CFG_SVH
`define IRCTU_AW 6
`define IRCTU_A_OPA 6'h00
`define IRCTU_A_OPB 6'h04
`define IRCTU_A_IMM 6'h08
`define IRCTU_A_CMD 6'h0C
`define IRCTU_A_RES 6'h10
`define IRCTU_A_FPX 6'h14
`define IRCTU_A_CR 6'h18
`define IRCTU_A_TBLO 6'h1C
`define IRCTU_A_TBHI 6'h20
`define IRCTU_A_STAT 6'h24
`define IRCTU_RESP_OK 2'h0
`define IRCTU_RESP_ERR 2'h2
`define IRCTU_TO_LGT 5'h01
`define IRCTU_TO_LLT 5'h02
`define IRCTU_TO_EQ 5'h04
`define IRCTU_TO_GT 5'h08
`define IRCTU_TO_LT 5'h10
`define IRCTU_TO_LGE 5'h05
`define IRCTU_TO_LLE 5'h06
`define IRCTU_TO_GE 5'h0C
`define IRCTU_TO_LE 5'h14
`define IRCTU_TO_NE 5'h18
`define IRCTU_CFZ 3'h0
`define IRCTU_BIT_MAX 5'h1F
`define IRCTU_HALF 16'h0000
`define IRCTU_W0 32'h00000000
`define IRCTU_TB0 64'h0000000000000000
`define IRCTU_TB1 64'h0000000000000001
`endif

// file: verilog/irctu_pkg.sv
// Types shared by the integer rotate, compare and trap unit.
// Assumes the constants header is on the include path.
package irctu_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_CMPW = 5'h01, OP_CMPLW = 5'h02, OP_CMPWI = 5'h03,
        OP_CMPLWI = 5'h04, OP_TW = 5'h05, OP_TWI = 5'h06, OP_CRXOR = 5'h07,
        OP_CREQV = 5'h08, OP_CRNOR = 5'h09, OP_CROR = 5'h0A, OP_ROTLW = 5'h0B,
        OP_RLWINM = 5'h0C, OP_RLWIMI = 5'h0D, OP_SUBF = 5'h0E, OP_SUBFC = 5'h0F,
        OP_SUBIC = 5'h10, OP_LIS = 5'h11, OP_MFTB = 5'h12, OP_MFTBU = 5'h13
    } irctu_op_t;
    typedef struct packed {
        logic [8:0] rsvd;
        logic [4:0] me;
        logic [4:0] mb;
        logic [4:0] sh;
        logic lbit;
        logic oe;
        logic rec;
        irctu_op_t op;
    } irctu_cmd_t;
    typedef struct packed {
        logic so;
        logic overflow_flag;
        logic carry_flag;
    } irctu_fpx_t;
    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic llt;
        logic lgt;
    } irctu_cmp_t;
endpackage : irctu_pkg

// file: verilog/irctu_core.sv
// Integer compare, trap, rotate and subtract datapath behind an AXI4-Lite slave.
// Assumes one clock, one asynchronous active-low reset and a single bus master.
// Notes on behaviour
// - Condition 4 traps on equal to register B or immediate.
// - Condition 8 traps on signed greater.
// - Condition 16 traps on signed less.
// - Condition 1 traps on unsigned greater.
// - Condition 2 traps on unsigned less.
// - Bits OR; 12 signed not-less, 20 not-greater.
// - Condition 24 traps on not equal.
// - 6 unsigned not-greater, 5 unsigned not-less.
// - Compares need length zero, write chosen field.
// - Bit ops XOR, equivalence, NOR, OR.
// - Register rotate uses low five bits.
// - Right rotate is left by 32-n.
// - Left shift fills low bits with zeros.
// - Right shift zeroes vacated high bits.
// - Left-justified extract zeroes the rest.
// - Right-justified extract clears higher bits.
// - Left insert keeps other destination bits.
// - Right insert keeps other destination bits.
// - Subtract is complement plus minuend plus one.
// - Overflow forms set flags; record sets field zero.
// - Immediate carrying subtract sets carry flag.
`timescale 1ns/100ps
`include "irctu_cfg.svh"
module irctu_core (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Write address and data.
    input wire logic [`IRCTU_AW-1:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    // Write response.
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // Read address and data.
    input wire logic [`IRCTU_AW-1:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // Trap request to the exception unit.
    output logic trap_o
);
    function automatic logic [31:0] f_sext(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : f_sext

    function automatic irctu_pkg::irctu_cmp_t f_cmp(input logic [31:0] a,
                                                   input logic [31:0] b);
        irctu_pkg::irctu_cmp_t c;
        c.lt = $signed(a) < $signed(b);
        c.gt = $signed(a) > $signed(b);
        c.eq = a == b;
        c.llt = a < b;
        c.lgt = a > b;
        return c;
    endfunction : f_cmp

    function automatic logic f_trap(input logic [4:0] to,
                                    input irctu_pkg::irctu_cmp_t c);
        return |(to & c);
    endfunction : f_trap

    function automatic logic [31:0] f_rotl(input logic [31:0] v,
                                           input logic [4:0] n);
        logic [63:0] t;
        t = {v, v} << n;
        return t[63:32];
    endfunction : f_rotl

    function automatic logic [31:0] f_mask(input logic [4:0] mb,
                                           input logic [4:0] me);
        logic [31:0] m;
        m = `IRCTU_W0;
        for (int i = 0; i < 32; i++) begin
            if (mb <= me) begin
                m[31-i] = (5'(i) >= mb) && (5'(i) <= me);
            end else begin
                m[31-i] = (5'(i) >= mb) || (5'(i) <= me);
            end
        end
        return m;
    endfunction : f_mask

    function automatic logic [31:0] f_setfld(input logic [31:0] cr,
                                             input logic [2:0] f,
                                             input logic [3:0] v);
        logic [31:0] r;
        r = cr;
        for (int k = 0; k < 8; k++) begin
            if (3'(k) == f) begin
                r[31-4*k -: 4] = v;
            end
        end
        return r;
    endfunction : f_setfld

    function automatic logic [31:0] f_merge(input logic [31:0] o,
                                            input logic [31:0] n,
                                            input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) begin
                r[8*k +: 8] = n[8*k +: 8];
            end
        end
        return r;
    endfunction : f_merge

    // Bus handshake state.
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [`IRCTU_AW-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_go, wr_hit;
    // Unit state.
    logic [31:0] opa_r, opa_nxt, opb_r, opb_nxt, res_r, res_nxt, cr_r, cr_nxt;
    logic [15:0] imm_r, imm_nxt;
    irctu_pkg::irctu_cmd_t cmd_r, cmd_nxt, cmd_w;
    irctu_pkg::irctu_fpx_t fpx_r, fpx_nxt;
    logic [63:0] tb_r, tb_nxt;
    logic err_r, err_nxt, trapl_r, trapl_nxt, trap_r, trap_nxt;
    logic exec;
    irctu_pkg::irctu_cmp_t cmp;
    logic [32:0] dif;
    logic [31:0] subtr, rot, msk;

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_awvalid_i && awready_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_awaddr_i;
        end
        if (s_wvalid_i && wready_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_wdata_i;
            wstrb_nxt = s_wstrb_i;
        end
        if (bvalid_r && s_bready_i) begin
            bvalid_nxt = 1'b0;
        end
        wr_go = aw_full_r && w_full_r && !bvalid_r;
        if (wr_go) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? `IRCTU_RESP_OK : `IRCTU_RESP_ERR;
        end
        awready_nxt = !aw_full_nxt;
        wready_nxt = !w_full_nxt;
    end

    always_comb begin
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_arvalid_i && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = `IRCTU_RESP_OK;
            unique case (s_araddr_i)
                `IRCTU_A_OPA: rdata_nxt = opa_r;
                `IRCTU_A_OPB: rdata_nxt = opb_r;
                `IRCTU_A_IMM: rdata_nxt = {`IRCTU_HALF, imm_r};
                `IRCTU_A_CMD: rdata_nxt = cmd_r;
                `IRCTU_A_RES: rdata_nxt = res_r;
                `IRCTU_A_FPX: rdata_nxt = {fpx_r, 29'h00000000};
                `IRCTU_A_CR: rdata_nxt = cr_r;
                `IRCTU_A_TBLO: rdata_nxt = tb_r[31:0];
                `IRCTU_A_TBHI: rdata_nxt = tb_r[63:32];
                `IRCTU_A_STAT: rdata_nxt = {30'h00000000, err_r, trapl_r};
                default: begin
                    rdata_nxt = `IRCTU_W0;
                    rresp_nxt = `IRCTU_RESP_ERR;
                end
            endcase
        end
        if (rvalid_r && s_rready_i) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_comb begin
        opa_nxt = opa_r;
        opb_nxt = opb_r;
        imm_nxt = imm_r;
        cmd_nxt = cmd_r;
        res_nxt = res_r;
        fpx_nxt = fpx_r;
        cr_nxt = cr_r;
        tb_nxt = tb_r + `IRCTU_TB1;
        err_nxt = err_r;
        trapl_nxt = trapl_r;
        trap_nxt = 1'b0;
        wr_hit = 1'b1;
        cmd_w = f_merge(cmd_r, wdata_r, wstrb_r);
        exec = 1'b0;
        cmp = f_cmp(opa_r, opb_r);
        subtr = opb_r;
        rot = f_rotl(opa_r, cmd_w.sh);
        msk = f_mask(cmd_w.mb, cmd_w.me);
        unique case (awaddr_r)
            `IRCTU_A_OPA, `IRCTU_A_OPB, `IRCTU_A_IMM, `IRCTU_A_CMD,
            `IRCTU_A_RES, `IRCTU_A_FPX, `IRCTU_A_CR, `IRCTU_A_TBLO,
            `IRCTU_A_TBHI, `IRCTU_A_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (wr_go) begin
            unique case (awaddr_r)
                `IRCTU_A_OPA: opa_nxt = f_merge(opa_r, wdata_r, wstrb_r);
                `IRCTU_A_OPB: opb_nxt = f_merge(opb_r, wdata_r, wstrb_r);
                `IRCTU_A_IMM: imm_nxt = imm_r ^ (imm_r ^ wdata_r[15:0]) &
                                        {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
                `IRCTU_A_CMD: begin
                    cmd_nxt = cmd_w;
                    exec = 1'b1;
                end
                `IRCTU_A_FPX: fpx_nxt = wdata_r[31:29];
                `IRCTU_A_CR: cr_nxt = f_merge(cr_r, wdata_r, wstrb_r);
                `IRCTU_A_TBLO: tb_nxt = {tb_r[63:32], wdata_r};
                `IRCTU_A_TBHI: tb_nxt = {wdata_r, tb_r[31:0]};
                default: ;
            endcase
        end
        if (cmd_w.op == irctu_pkg::OP_CMPWI || cmd_w.op == irctu_pkg::OP_TWI ||
            cmd_w.op == irctu_pkg::OP_SUBIC) begin
            subtr = f_sext(imm_r);
        end
        if (cmd_w.op == irctu_pkg::OP_CMPLWI) begin
            subtr = {`IRCTU_HALF, imm_r};
        end
        cmp = f_cmp(opa_r, subtr);
        dif = {1'b0, ~subtr} + {1'b0, opa_r} + 33'h000000001;
        if (exec) begin
            err_nxt = 1'b0;
            unique case (cmd_w.op)
                irctu_pkg::OP_NOP: ;
                irctu_pkg::OP_CMPW, irctu_pkg::OP_CMPLW,
                irctu_pkg::OP_CMPWI, irctu_pkg::OP_CMPLWI: begin
                    if (cmd_w.lbit) begin
                        err_nxt = 1'b1;
                    end else if (cmd_w.op == irctu_pkg::OP_CMPW ||
                                 cmd_w.op == irctu_pkg::OP_CMPWI) begin
                        cr_nxt = f_setfld(cr_r, cmd_w.mb[2:0],
                                          {cmp.lt, cmp.gt, cmp.eq, fpx_r.so});
                    end else begin
                        cr_nxt = f_setfld(cr_r, cmd_w.mb[2:0],
                                          {cmp.llt, cmp.lgt, cmp.eq, fpx_r.so});
                    end
                end
                irctu_pkg::OP_TW, irctu_pkg::OP_TWI: begin
                    trap_nxt = f_trap(cmd_w.mb, cmp);
                    trapl_nxt = trap_nxt;
                end
                irctu_pkg::OP_CRXOR: cr_nxt[`IRCTU_BIT_MAX - cmd_w.sh] =
                    cr_r[`IRCTU_BIT_MAX - cmd_w.mb] ^ cr_r[`IRCTU_BIT_MAX - cmd_w.me];
                irctu_pkg::OP_CREQV: cr_nxt[`IRCTU_BIT_MAX - cmd_w.sh] =
                    ~(cr_r[`IRCTU_BIT_MAX - cmd_w.mb] ^ cr_r[`IRCTU_BIT_MAX - cmd_w.me]);
                irctu_pkg::OP_CRNOR: cr_nxt[`IRCTU_BIT_MAX - cmd_w.sh] =
                    ~(cr_r[`IRCTU_BIT_MAX - cmd_w.mb] | cr_r[`IRCTU_BIT_MAX - cmd_w.me]);
                irctu_pkg::OP_CROR: cr_nxt[`IRCTU_BIT_MAX - cmd_w.sh] =
                    cr_r[`IRCTU_BIT_MAX - cmd_w.mb] | cr_r[`IRCTU_BIT_MAX - cmd_w.me];
                irctu_pkg::OP_ROTLW: res_nxt = f_rotl(opa_r, opb_r[4:0]);
                irctu_pkg::OP_RLWINM: res_nxt = rot & msk;
                irctu_pkg::OP_RLWIMI: res_nxt = (rot & msk) | (opb_r & ~msk);
                irctu_pkg::OP_SUBF, irctu_pkg::OP_SUBFC, irctu_pkg::OP_SUBIC: begin
                    res_nxt = dif[31:0];
                    if (cmd_w.op != irctu_pkg::OP_SUBF) begin
                        fpx_nxt.carry_flag = dif[32];
                    end
                    if (cmd_w.oe && cmd_w.op != irctu_pkg::OP_SUBIC) begin
                        fpx_nxt.overflow_flag = (opa_r[31] ^ subtr[31]) &
                                                (dif[31] ^ opa_r[31]);
                        fpx_nxt.so = fpx_r.so | fpx_nxt.overflow_flag;
                    end
                end
                irctu_pkg::OP_LIS: res_nxt = {imm_r, `IRCTU_HALF};
                irctu_pkg::OP_MFTB: res_nxt = tb_r[31:0];
                irctu_pkg::OP_MFTBU: res_nxt = tb_r[63:32];
                default: err_nxt = 1'b1;
            endcase
            if (cmd_w.rec && (cmd_w.op == irctu_pkg::OP_ROTLW ||
                cmd_w.op == irctu_pkg::OP_RLWINM || cmd_w.op == irctu_pkg::OP_RLWIMI ||
                cmd_w.op == irctu_pkg::OP_SUBF || cmd_w.op == irctu_pkg::OP_SUBFC ||
                cmd_w.op == irctu_pkg::OP_SUBIC)) begin
                cr_nxt = f_setfld(cr_nxt, `IRCTU_CFZ,
                                  {$signed(res_nxt) < 0, $signed(res_nxt) > 0,
                                   res_nxt == `IRCTU_W0, fpx_nxt.so});
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= `IRCTU_A_OPA;
            wdata_r <= `IRCTU_W0;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `IRCTU_RESP_OK;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= `IRCTU_W0;
            rresp_r <= `IRCTU_RESP_OK;
            opa_r <= `IRCTU_W0;
            opb_r <= `IRCTU_W0;
            imm_r <= `IRCTU_HALF;
            cmd_r <= `IRCTU_W0;
            res_r <= `IRCTU_W0;
            fpx_r <= 3'h0;
            cr_r <= `IRCTU_W0;
            tb_r <= `IRCTU_TB0;
            err_r <= 1'b0;
            trapl_r <= 1'b0;
            trap_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            opa_r <= opa_nxt;
            opb_r <= opb_nxt;
            imm_r <= imm_nxt;
            cmd_r <= cmd_nxt;
            res_r <= res_nxt;
            fpx_r <= fpx_nxt;
            cr_r <= cr_nxt;
            tb_r <= tb_nxt;
            err_r <= err_nxt;
            trapl_r <= trapl_nxt;
            trap_r <= trap_nxt;
        end
    end

    assign s_awready_o = awready_r;
    assign s_wready_o = wready_r;
    assign s_bvalid_o = bvalid_r;
    assign s_bresp_o = bresp_r;
    assign s_arready_o = arready_r;
    assign s_rvalid_o = rvalid_r;
    assign s_rdata_o = rdata_r;
    assign s_rresp_o = rresp_r;
    assign trap_o = trap_r;

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    logic twi_go;
    assign twi_go = exec && cmd_w.op == irctu_pkg::OP_TWI;

    AST_TRAP_EQ: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_EQ && opa_r == f_sext(imm_r) |=> trap_o)
        else $error("Equal trap missed.");
    AST_TRAP_GT: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_GT |=> trap_o == $past(cmp.gt))
        else $error("Signed greater trap wrong.");
    AST_TRAP_LT: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_LT |=> trap_o == $past(cmp.lt))
        else $error("Signed less trap wrong.");
    AST_TRAP_LGT: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_LGT |=> trap_o == ($past(opa_r) > $past(subtr)))
        else $error("Unsigned greater trap wrong.");
    AST_TRAP_LLT: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_LLT |=> trap_o == ($past(opa_r) < $past(subtr)))
        else $error("Unsigned less trap wrong.");
    AST_TRAP_GE: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_GE |=> trap_o != $past(cmp.lt))
        else $error("Signed not-less trap wrong.");
    AST_TRAP_NE: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_NE |=> trap_o == ($past(opa_r) != $past(subtr)))
        else $error("Not-equal trap wrong.");
    AST_TRAP_LLE: assert property (
        twi_go && cmd_w.mb == `IRCTU_TO_LLE |=> trap_o == ($past(opa_r) <= $past(subtr)))
        else $error("Unsigned not-greater trap wrong.");
    AST_SUB_CARRY: assert property (
        exec && cmd_w.op == irctu_pkg::OP_SUBFC |=>
        res_r == $past(opa_r) - $past(opb_r) &&
        fpx_r.carry_flag == ($past(opa_r) >= $past(opb_r)))
        else $error("Carrying subtract wrong.");
    AST_LIS: assert property (
        exec && cmd_w.op == irctu_pkg::OP_LIS |=> res_r[15:0] == `IRCTU_HALF &&
        res_r[31:16] == $past(imm_r))
        else $error("Shifted immediate load wrong.");
    AST_NO_TRAP: assert property (
        !twi_go && !(exec && cmd_w.op == irctu_pkg::OP_TW) |=> !trap_o)
        else $error("Trap raised without trap command.");

    COV_TRAP: cover property (twi_go ##1 trap_o);
    COV_CMP: cover property (exec && cmd_w.op == irctu_pkg::OP_CMPW);
    COV_INS: cover property (exec && cmd_w.op == irctu_pkg::OP_RLWIMI);
    COV_RD: cover property (s_rvalid_o && s_rready_i);
endmodule : irctu_core

// file: sim/irctu_core_tb.sv
// Self-checking bench of the rotate, compare and trap unit, driven over AXI4-Lite.
// Assumes the unit's package and constants header are compiled beforehand.
`timescale 1ns/100ps
`include "irctu_cfg.svh"
module irctu_core_tb;
    logic mclk_i, rstn_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, trap_o, cy, ovf, pa, pb;
    logic [`IRCTU_AW-1:0] s_awaddr_i, s_araddr_i;
    logic [31:0] s_wdata_i, s_rdata_o, rd, tr, a, b, x, e, fm;
    logic [3:0] s_wstrb_i;
    logic [1:0] s_bresp_o, s_rresp_o, rsp;
    logic [4:0] codes [10] = '{5'h04, 5'h08, 5'h10, 5'h01, 5'h02, 5'h0C, 5'h14, 5'h18, 5'h06, 5'h05};
    int error_cnt, tests_run, k, n, p;
    irctu_pkg::irctu_cmd_t c;

    irctu_core irctu_core_i (.mclk_i, .rstn_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
        .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
        .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
        .s_rready_i, .trap_o);

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic hang;
        error_cnt++;
        $display("MISMATCH handshake exp 1 seen 0");
        summarize();
    endtask : hang

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [`IRCTU_AW-1:0] ad, input logic [31:0] d);
        @(posedge mclk_i);
        s_awaddr_i <= ad;
        s_wdata_i <= d;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (s_awready_o) s_awvalid_i <= 1'b0;
            if (s_wready_o) s_wvalid_i <= 1'b0;
            if (s_bvalid_o) begin
                rsp = s_bresp_o;
                tr = 32'(trap_o);
                s_bready_i <= 1'b0;
                return;
            end
        end
        hang();
    endtask : wr

    task automatic rd_reg(input logic [`IRCTU_AW-1:0] ad);
        @(posedge mclk_i);
        s_araddr_i <= ad;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (s_arready_o) s_arvalid_i <= 1'b0;
            if (s_rvalid_o) begin
                rd = s_rdata_o;
                rsp = s_rresp_o;
                s_rready_i <= 1'b0;
                return;
            end
        end
        hang();
    endtask : rd_reg

    task automatic exec(input logic [31:0] ra, rb, im, input irctu_pkg::irctu_cmd_t cm);
        wr(`IRCTU_A_OPA, ra);
        wr(`IRCTU_A_OPB, rb);
        wr(`IRCTU_A_IMM, im);
        wr(`IRCTU_A_CMD, cm);
    endtask : exec

    function automatic irctu_pkg::irctu_cmd_t mk(input logic [4:0] o, input int s, bb, m);
        mk = '0;
        mk.op = irctu_pkg::irctu_op_t'(o);
        mk.sh = 5'(s);
        mk.mb = 5'(bb);
        mk.me = 5'(m);
    endfunction : mk

    function automatic logic [31:0] trap_f(input logic [4:0] t, input logic [31:0] u, v);
        return {31'h0, (t[4] && $signed(u) < $signed(v)) || (t[3] && $signed(u) > $signed(v))
            || (t[2] && u == v) || (t[1] && u < v) || (t[0] && u > v)};
    endfunction : trap_f

    initial begin
        {rstn_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
        {s_awaddr_i, s_araddr_i, s_wdata_i} = '0;
        s_wstrb_i = 4'hF;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'h2BCB));
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd_reg(`IRCTU_A_RES);
        check("result", rd, 32'h0);
        rd_reg(6'h28);
        check("rresp", {30'h0, rsp}, {30'h0, `IRCTU_RESP_ERR});
        wr(6'h2C, 32'h1);
        check("bresp", {30'h0, rsp}, {30'h0, `IRCTU_RESP_ERR});
        $display("done map");
        for (int i = 0; i < 60; i++) begin
            x = $urandom;
            b = {{16{x[15]}}, x[15:0]};
            a = (i < 30) ? b + i / 10 - 1 : (i < 40) ? b ^ 32'h80000000 : $urandom;
            exec(a, b, x, mk((i / 10) % 2 ? 5'h06 : 5'h05, 0, codes[i % 10], 0));
            e = trap_f(codes[i % 10], a, b);
            if (i % 10 < 5) check("trap", tr, e);
            else check("trap", tr, e);
        end
        $display("done trap");
        for (int i = 0; i < 8; i++) begin
            x = $urandom;
            k = i % 4;
            b = (k == 2) ? {{16{x[15]}}, x[15:0]} : (k == 3) ? {16'h0, x[15:0]} : x;
            a = (i < 4) ? b : $urandom;
            c = mk(5'(1 + k), 0, i, 0);
            c.lbit = (i == 5);
            wr(`IRCTU_A_CR, 32'h0);
            exec(a, x, x, c);
            pa = k[0] ? a < b : $signed(a) < $signed(b);
            pb = k[0] ? a > b : $signed(a) > $signed(b);
            e = (i == 5) ? 32'h0 : {pa, pb, a == b, 29'h0} >> (4 * i);
            rd_reg(`IRCTU_A_CR);
            check("cmp", rd, e);
            rd_reg(`IRCTU_A_STAT);
            check("err", rd & 32'h2, (i == 5) ? 32'h2 : 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            x = $urandom;
            n = $urandom % 32;
            p = (i < 4) ? n : $urandom % 32;
            k = (i < 4) ? p : $urandom % 32;
            wr(`IRCTU_A_CR, x);
            exec(0, 0, 0, mk(5'(7 + i % 4), n, p, k));
            pa = x[31 - p];
            pb = x[31 - k];
            fm = {28'h0, pa | pb, ~(pa | pb), pa ~^ pb, pa ^ pb};
            e = x;
            e[31 - n] = fm[i % 4];
            rd_reg(`IRCTU_A_CR);
            check("crbit", rd, e);
        end
        $display("done cr");
        for (int i = 0; i < 32; i++) begin
            a = $urandom;
            b = $urandom;
            n = $urandom % 31 + 1;
            p = $urandom % (33 - n);
            fm = (32'hFFFFFFFF >> p) & ~(32'hFFFFFFFF >> (p + n));
            case (i % 8)
                0: e = (a << b[4:0]) | (a >> (32 - b[4:0]));
                1: e = (a >> n) | (a << (32 - n));
                2: e = a << n;
                3: e = a >> n;
                4: e = (a << p) & ~(32'hFFFFFFFF >> n);
                5: e = (a << p) >> (32 - n);
                6: e = (b & ~fm) | ((a >> p) & fm);
                default: e = (b & ~fm) | ((a << (32 - p - n)) & fm);
            endcase
            case (i % 8)
                0: c = mk(5'h0B, 0, 0, 31);
                1: c = mk(5'h0C, 32 - n, 0, 31);
                2: c = mk(5'h0C, n, 0, 31 - n);
                3: c = mk(5'h0C, 32 - n, n, 31);
                4: c = mk(5'h0C, p, 0, n - 1);
                5: c = mk(5'h0C, p + n, 32 - n, 31);
                6: c = mk(5'h0D, 32 - p, p, p + n - 1);
                default: c = mk(5'h0D, 32 - p - n, p, p + n - 1);
            endcase
            exec(a, b, 0, c);
            rd_reg(`IRCTU_A_RES);
            if (i % 8 < 4) check("rot", rd, e);
            else check("field", rd, e);
        end
        $display("done rotate");
        for (int i = 0; i < 12; i++) begin
            k = i % 3;
            a = (i < 3) ? 32'h80000000 : $urandom;
            x = (i < 3) ? 32'h1 : (i < 6) ? a : $urandom;
            b = (k == 2) ? {{16{x[15]}}, x[15:0]} : x;
            wr(`IRCTU_A_FPX, 32'h0);
            c = mk(5'(14 + k), 0, 0, 0);
            c.rec = 1'b1;
            c.oe = 1'b1;
            exec(a, x, x, c);
            {cy, e} = {1'b0, a} + {1'b0, ~b} + 33'h1;
            ovf = (k < 2) && (a[31] != b[31]) && (e[31] != a[31]);
            rd_reg(`IRCTU_A_RES);
            check("diff", rd, e);
            rd_reg(`IRCTU_A_FPX);
            fm = {ovf, ovf, cy && k > 0, 29'h0};
            check("fpx", rd & 32'hE0000000, fm);
            rd_reg(`IRCTU_A_CR);
            fm = {e[31], !e[31] && e != 0, e == 0, ovf, 28'h0};
            check("cfz", rd & 32'hF0000000, fm);
        end
        for (int i = 0; i < 4; i++) begin
            x = $urandom;
            exec(0, 0, x, mk(5'h11, 0, 0, 0));
            rd_reg(`IRCTU_A_RES);
            check("lis", rd, {x[15:0], 16'h0});
        end
        wr(`IRCTU_A_TBHI, x);
        wr(`IRCTU_A_TBLO, 32'h0);
        exec(0, 0, 0, mk(5'h13, 0, 0, 0));
        rd_reg(`IRCTU_A_RES);
        check("tbhi", rd, x);
        $display("done arith");
        summarize();
    end
endmodule : irctu_core_tb
